// ### logic/slf_pkg.sv
package slf_pkg;
  // ---------------------------------------------------------------
  // controller cycle timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 25000000;
  localparam int unsigned CYCLE_TIME_MS = 5;
  localparam int unsigned CYCLE_CLKS = (CLK_FREQ_HZ / 1000) * CYCLE_TIME_MS;
  localparam int unsigned CYCLE_CNT_W = 18;
  // ---------------------------------------------------------------
  // element sizes
  // ---------------------------------------------------------------
  localparam int unsigned OR7_WIDTH = 7;
  localparam int unsigned OR8_WIDTH = 8;
  localparam int unsigned ROUTE_WIDTH = 8;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic RST_MEM_Q = 1'h0;
  localparam logic RST_OUT = 1'h0;
  // ---------------------------------------------------------------
  // edge selection
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SLF_EDGE_RISE,
    SLF_EDGE_FALL,
    SLF_EDGE_BOTH
  } slf_edge_mode_t;
  localparam slf_edge_mode_t EDGE_MODE_DEFAULT = SLF_EDGE_RISE;
endpackage

// ### logic/slf_logic_blocks.sv
`timescale 1ns/10ps
// Functional notes
// - seven and eight input OR, any active
// - two input XOR, active when different
// - two input XNOR, active when equal
// - route copies one input to eight outputs
// - fault present forces all route outputs low
// - memory cell holds last set or clear
// - set and clear together: clear wins
// - idle keeps state; inverted output always complement
// - edge pulse lasts one controller cycle per edge; edges in consecutive cycles keep it high
// - rising, falling or both; rising default
// - no fault monitoring or fault indication
module slf_logic_blocks
  import slf_pkg::*;
#(
  parameter int unsigned CYC_CLKS = CYCLE_CLKS
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [OR7_WIDTH-1:0] or7_in,
  input wire logic [OR8_WIDTH-1:0] or8_in,
  input wire logic xor_a,
  input wire logic xor_b,
  input wire logic xnor_a,
  input wire logic xnor_b,
  input wire logic route_in,
  input wire logic route_fault,
  input wire logic mem_set,
  input wire logic mem_clear,
  input wire logic edge_in,
  input wire logic [1:0] edge_mode,
  output logic cycle_tick,
  output logic or7_out,
  output logic or8_out,
  output logic xor_out,
  output logic xnor_out,
  output logic [ROUTE_WIDTH-1:0] route_out,
  output logic mem_q,
  output logic mem_q_n,
  output logic edge_pulse
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  localparam int unsigned SYNC_W = OR7_WIDTH + OR8_WIDTH + 11;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_ff1;
  logic [SYNC_W-1:0] sync_ff2;
  assign sync_raw = {or7_in, or8_in, xor_a, xor_b, xnor_a, xnor_b, route_in,
                     route_fault, mem_set, mem_clear, edge_in, edge_mode};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_ff1 <= '0;
      sync_ff2 <= '0;
    end else begin
      sync_ff1 <= sync_raw;
      sync_ff2 <= sync_ff1;
    end
  end

  logic [OR7_WIDTH-1:0] s_or7;
  logic [OR8_WIDTH-1:0] s_or8;
  logic s_xa;
  logic s_xb;
  logic s_na;
  logic s_nb;
  logic s_rin;
  logic s_rfault;
  logic s_set;
  logic s_clr;
  logic s_edge;
  logic [1:0] s_mode;
  assign {s_or7, s_or8, s_xa, s_xb, s_na, s_nb, s_rin, s_rfault, s_set, s_clr,
          s_edge, s_mode} = sync_ff2;

  // ---------------------------------------------------------------
  // controller cycle tick
  // ---------------------------------------------------------------
  localparam logic [CYCLE_CNT_W-1:0] CYCLE_LAST = CYCLE_CNT_W'(CYC_CLKS - 1);
  logic [CYCLE_CNT_W-1:0] cycle_cnt;
  logic cycle_wrap;
  assign cycle_wrap = (cycle_cnt == CYCLE_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cycle_cnt <= '0;
      cycle_tick <= 1'h0;
    end else begin
      cycle_cnt <= cycle_wrap ? '0 : cycle_cnt + 1'h1;
      cycle_tick <= cycle_wrap;
    end
  end

  // ---------------------------------------------------------------
  // combinational next values
  // ---------------------------------------------------------------
  logic next_or7;
  logic next_or8;
  logic next_xor;
  logic next_xnor;
  logic [ROUTE_WIDTH-1:0] next_route;
  logic next_mem_q;
  logic rise_seen;
  logic fall_seen;
  logic next_edge;
  logic edge_prev;
  slf_edge_mode_t mode_sel;

  assign next_or7 = |s_or7;
  assign next_or8 = |s_or8;
  assign next_xor = s_xa ^ s_xb;
  assign next_xnor = ~(s_na ^ s_nb);
  assign next_route = s_rfault ? '0 : {ROUTE_WIDTH{s_rin}};
  assign next_mem_q = s_clr ? 1'h0 : (s_set ? 1'h1 : mem_q);
  assign mode_sel = (s_mode == 2'h1) ? SLF_EDGE_FALL :
                    (s_mode == 2'h2) ? SLF_EDGE_BOTH : EDGE_MODE_DEFAULT;
  assign rise_seen = s_edge & ~edge_prev;
  assign fall_seen = ~s_edge & edge_prev;

  always_comb begin
    case (mode_sel)
      SLF_EDGE_RISE: next_edge = rise_seen;
      SLF_EDGE_FALL: next_edge = fall_seen;
      SLF_EDGE_BOTH: next_edge = rise_seen | fall_seen;
      default: next_edge = rise_seen;
    endcase
  end

  // ---------------------------------------------------------------
  // evaluation once per controller cycle
  // ---------------------------------------------------------------
  // outputs depend only on inputs and stored state; nothing flags faults
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      or7_out <= RST_OUT;
      or8_out <= RST_OUT;
      xor_out <= RST_OUT;
      xnor_out <= RST_OUT;
      route_out <= '0;
      mem_q <= RST_MEM_Q;
      mem_q_n <= ~RST_MEM_Q;
      edge_prev <= 1'h0;
      edge_pulse <= RST_OUT;
    end else if (cycle_wrap) begin
      or7_out <= next_or7;
      or8_out <= next_or8;
      xor_out <= next_xor;
      xnor_out <= next_xnor;
      route_out <= next_route;
      mem_q <= next_mem_q;
      mem_q_n <= ~next_mem_q;
      edge_prev <= s_edge;
      edge_pulse <= next_edge;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_tick_or8_any;
    cycle_wrap && (|s_or8);
  endsequence

  a_or_wide_any: assert property (s_tick_or8_any |=> or8_out)
    else $error("or8 output not active with active input");
  a_or7_none: assert property (cycle_wrap && !(|s_or7) |=> !or7_out)
    else $error("or7 output active with no input");
  a_xor_value: assert property (cycle_wrap |=> xor_out == $past(s_xa ^ s_xb))
    else $error("xor output wrong");
  a_xnor_value: assert property (cycle_wrap |=> xnor_out == $past(s_na ~^ s_nb))
    else $error("xnor output wrong");
  a_route_follow: assert property (cycle_wrap && !s_rfault |=> route_out == {8{$past(s_rin)}})
    else $error("route outputs do not follow input");
  a_route_fault_low: assert property (cycle_wrap && s_rfault |=> route_out == '0)
    else $error("route outputs not forced low on fault");
  a_mem_set: assert property (cycle_wrap && s_set && !s_clr |=> mem_q && !mem_q_n)
    else $error("memory not set");
  a_mem_clear_wins: assert property (cycle_wrap && s_clr |=> !mem_q && mem_q_n)
    else $error("clear did not win");
  a_mem_hold: assert property (cycle_wrap && !s_set && !s_clr |=> $stable(mem_q))
    else $error("memory changed while idle");
  a_mem_complement: assert property (mem_q_n == !mem_q)
    else $error("inverted output not complement");
  a_edge_one_cycle: assert property (
    edge_pulse && cycle_wrap |=> !edge_pulse || $past(next_edge))
    else $error("edge pulse held without new edge");
  a_edge_stable_cycle: assert property (!cycle_wrap |=> $stable(edge_pulse))
    else $error("edge pulse changed inside a cycle");
  a_edge_rise_default: assert property (
    cycle_wrap && s_mode == 2'h0 && rise_seen |=> edge_pulse)
    else $error("rising edge missed in default mode");
  a_edge_fall_ignored: assert property (
    cycle_wrap && s_mode == 2'h0 && fall_seen |=> !edge_pulse)
    else $error("falling edge reported in rising mode");

  // ---------------------------------------------------------------
  // further output assertions
  // ---------------------------------------------------------------
  sequence s_tick_or7_any;
    cycle_wrap && (|s_or7);
  endsequence

  sequence s_tick_or8_none;
    cycle_wrap && !(|s_or8);
  endsequence

  sequence s_tick_idle;
    !cycle_wrap;
  endsequence

  a_or7_any: assert property (
    s_tick_or7_any |=> or7_out)
    else $error("or7 output not active with active input");
  a_or8_none: assert property (
    s_tick_or8_none |=> !or8_out)
    else $error("or8 output active with no input");
  a_or7_value: assert property (
    cycle_wrap |=> or7_out == $past(|s_or7))
    else $error("or7 output wrong");
  a_or8_value: assert property (
    cycle_wrap |=> or8_out == $past(|s_or8))
    else $error("or8 output wrong");
  a_route_low_in: assert property (
    cycle_wrap && !s_rin |=> route_out == '0)
    else $error("route outputs active with low input");
  a_route_same: assert property (
    route_out == {ROUTE_WIDTH{route_out[0]}})
    else $error("route outputs differ from each other");
  a_or_stable_cycle: assert property (
    s_tick_idle |=> $stable(or7_out) && $stable(or8_out))
    else $error("or outputs changed inside a cycle");
  a_gate_stable_cycle: assert property (
    s_tick_idle |=> $stable(xor_out) && $stable(xnor_out) && $stable(route_out))
    else $error("gate outputs changed inside a cycle");
  a_mem_stable_cycle: assert property (
    s_tick_idle |=> $stable(mem_q))
    else $error("memory changed inside a cycle");
  a_mem_clear_only: assert property (
    cycle_wrap && s_clr && !s_set |=> !mem_q)
    else $error("memory not cleared");

  // ---------------------------------------------------------------
  // edge mode assertions
  // ---------------------------------------------------------------
  sequence s_tick_fall_mode;
    cycle_wrap && s_mode == 2'h1;
  endsequence

  sequence s_tick_both_mode;
    cycle_wrap && s_mode == 2'h2;
  endsequence

  sequence s_tick_spare_mode;
    cycle_wrap && s_mode == 2'h3;
  endsequence

  a_fall_mode_seen: assert property (
    s_tick_fall_mode ##0 fall_seen |=> edge_pulse)
    else $error("falling edge missed in falling mode");
  a_fall_mode_rise: assert property (
    s_tick_fall_mode ##0 rise_seen |=> !edge_pulse)
    else $error("rising edge reported in falling mode");
  a_both_mode_rise: assert property (
    s_tick_both_mode ##0 rise_seen |=> edge_pulse)
    else $error("rising edge missed in both mode");
  a_both_mode_fall: assert property (
    s_tick_both_mode ##0 fall_seen |=> edge_pulse)
    else $error("falling edge missed in both mode");
  a_spare_mode_rise: assert property (
    s_tick_spare_mode ##0 rise_seen |=> edge_pulse)
    else $error("rising edge missed in spare mode");
  a_edge_quiet: assert property (
    cycle_wrap && (s_edge == edge_prev) |=> !edge_pulse)
    else $error("edge pulse without an input edge");
  a_edge_history: assert property (
    cycle_wrap |=> edge_prev == $past(s_edge))
    else $error("edge history not updated");
  a_edge_on_tick: assert property (
    $rose(edge_pulse) |-> cycle_tick)
    else $error("edge pulse rose outside an evaluation");

  // ---------------------------------------------------------------
  // cycle tick assertions
  // ---------------------------------------------------------------
  a_tick_single: assert property (
    cycle_tick |=> !cycle_tick)
    else $error("cycle tick longer than one clock");
  a_tick_at_wrap: assert property (
    cycle_wrap |=> cycle_tick && cycle_cnt == '0)
    else $error("cycle tick not at counter wrap");
  a_tick_only_wrap: assert property (
    !cycle_wrap |=> !cycle_tick)
    else $error("cycle tick without counter wrap");

endmodule

// ### sim/slf_tb.sv
`timescale 1ns/10ps
// ---------------------------------------------------------------
// bench for the function block library
// ---------------------------------------------------------------
module tb
  import slf_pkg::*;
;
  `define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
  localparam int unsigned TB_CYC = 64;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [OR7_WIDTH-1:0] or7_in = '0;
  logic [OR8_WIDTH-1:0] or8_in = '0;
  logic xor_a = 1'h0, xor_b = 1'h0, xnor_a = 1'h0, xnor_b = 1'h0;
  logic route_in = 1'h0, route_fault = 1'h0, mem_set = 1'h0, mem_clear = 1'h0;
  logic edge_in = 1'h0;
  logic [1:0] edge_mode = 2'h0;
  logic cycle_tick, or7_out, or8_out, xor_out, xnor_out, mem_q, mem_q_n, edge_pulse;
  logic [ROUTE_WIDTH-1:0] route_out;
  logic [14:0] obs;
  logic [14:0] e;
  logic [14:0] exp_q[$];
  logic [4:0] tbl [9] = '{5'h14, 5'h04, 5'h18, 5'h05, 5'h11, 5'h0E, 5'h02, 5'h07, 5'h07};
  logic mq = 1'h0;
  logic prv = 1'h0;
  int err_total = 0;
  int cmp_count = 0;
  assign obs = {or7_out, or8_out, xor_out, xnor_out, route_out, mem_q, mem_q_n, edge_pulse};
  always #20 clk = ~clk;
  slf_logic_blocks #(.CYC_CLKS(TB_CYC)) dut (.clk(clk), .sys_rst(sys_rst), .or7_in(or7_in),
    .or8_in(or8_in),
    .xor_a(xor_a), .xor_b(xor_b), .xnor_a(xnor_a), .xnor_b(xnor_b), .route_in(route_in),
    .route_fault(route_fault), .mem_set(mem_set), .mem_clear(mem_clear), .edge_in(edge_in),
    .edge_mode(edge_mode), .cycle_tick(cycle_tick), .or7_out(or7_out), .or8_out(or8_out),
    .xor_out(xor_out), .xnor_out(xnor_out), .route_out(route_out), .mem_q(mem_q),
    .mem_q_n(mem_q_n), .edge_pulse(edge_pulse));
  task automatic conclude;
    $display("errors %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // monitor: oldest note against each evaluation
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (cycle_tick === 1'h1) begin
      if (exp_q.size() == 0) begin
        err_total++;
        $display("mismatch t=%0t evaluation without note", $time);
      end else begin
        e = exp_q.pop_front();
        `CHK(obs[14:13], e[14:13])
        `CHK(obs[12], e[12])
        `CHK(obs[11], e[11])
        `CHK(obs[10:3], e[10:3])
        `CHK(obs[2:1], e[2:1])
        `CHK(obs[0], e[0])
      end
    end
  end
  // ---------------------------------------------------------------
  // driver and expected values
  // ---------------------------------------------------------------
  initial begin
    int i;
    int k;
    logic [4:0] v;
    logic [14:0] x;
    logic [7:0] r;
    void'($urandom(86));
    repeat (2) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'h0;
    `CHK(obs, 15'h0002)
    for (i = 0; i < 9; i++) begin
      v = tbl[i];
      r = 8'($urandom);
      case (i % 3)
        0: r = 8'h00;
        1: r = 8'h01 << r[2:0];
        default: ;
      endcase
      or8_in = r;
      or7_in = r[6:0];
      xor_a = i[0];
      xor_b = i[1];
      xnor_a = i[0];
      xnor_b = i[2];
      route_in = 1'($urandom);
      route_fault = i[0];
      mem_set = v[4];
      mem_clear = v[3];
      edge_in = v[2];
      edge_mode = v[1:0];
      mq = v[3] ? 1'h0 : (v[4] ? 1'h1 : mq);
      case (v[1:0])
        2'h1: x[0] = prv & ~v[2];
        2'h2: x[0] = prv ^ v[2];
        default: x[0] = v[2] & ~prv;
      endcase
      prv = v[2];
      x[14:1] = {|r[6:0], |r, xor_a ^ xor_b, ~(xnor_a ^ xnor_b),
        route_fault ? 8'h00 : {8{route_in}}, mq, ~mq};
      exp_q.push_back(x);
      k = 0;
      do begin
        @(negedge clk);
        k++;
      end while (cycle_tick !== 1'h1 && k < 4 * TB_CYC);
      if (k >= 4 * TB_CYC) begin
        err_total++;
        $display("mismatch t=%0t no evaluation", $time);
      end
      if (i > 0) `CHK(k, TB_CYC)
    end
    @(negedge clk);
    conclude();
  end
  initial begin
    #100000;
    err_total++;
    $display("mismatch t=%0t watchdog", $time);
    conclude();
  end
endmodule
